// ### hdl/uhc_chan0_engine.sv
`timescale 1ns/10ps
`default_nettype none
module uhc_chan0_engine
(
   input  wire logic pclk,
   input  wire logic presetn,
   uhc_xact_if.eng   x
);
   typedef struct packed {
      uhc_pkg::uhc_eng_t st;
      logic [1:0]        stage;
      logic              tok_valid;
      logic [1:0]        tok_kind;
      logic [6:0]        tok_len;
      logic              launch_clr;
      logic              assist_clr;
      logic              dec;
      logic [6:0]        dec_bytes;
   } uhc_eng_state_t;

   uhc_eng_state_t q;
   uhc_eng_state_t d;

   function automatic logic [6:0] plain_len(input logic [1:0] k, input logic [6:0] mps,
                                            input logic [15:0] rem);
      logic [6:0] r;
      r = mps;
      if (k == uhc_pkg::KIND_SETUP)
         r = uhc_pkg::SETUP_LEN;
      else if (k == uhc_pkg::KIND_OUT && rem < {9'h000, mps})
         r = rem[6:0]; // RULE9
      return r;
   endfunction

   // -------------------------------------------------------------
   // Transaction sequencing.
   // -------------------------------------------------------------
   always_comb
   begin
      logic [1:0] dkind;
      logic [1:0] skind;
      dkind = x.plan_in ? uhc_pkg::KIND_IN : uhc_pkg::KIND_OUT;
      skind = (x.plan_data && !x.plan_in) ? uhc_pkg::KIND_IN : uhc_pkg::KIND_OUT;
      if (!x.plan_data)
         skind = uhc_pkg::KIND_IN;
      d = q;
      d.tok_valid = 1'b0;
      d.launch_clr = 1'b0;
      d.assist_clr = 1'b0;
      d.dec = 1'b0;
      unique case (q.st)
         uhc_pkg::UHC_ENG_IDLE:
         begin
            // A clear pulse still in flight means the register bit is stale for one cycle.
            if (x.assist_go && !q.assist_clr)
            begin
               d.stage = uhc_pkg::STG_SETUP; // RULE16
               d.tok_kind = uhc_pkg::KIND_SETUP; // RULE3
               d.tok_len = uhc_pkg::SETUP_LEN;
               d.tok_valid = 1'b1;
               d.st = uhc_pkg::UHC_ENG_WAIT;
            end
            else if (x.launch && !q.launch_clr && !q.assist_clr)
            begin
               d.tok_kind = x.kind; // RULE1
               d.tok_len = plain_len(x.kind, x.max_pkt, x.remaining);
               d.tok_valid = 1'b1; // RULE15
               d.st = uhc_pkg::UHC_ENG_WAIT;
            end
         end
         uhc_pkg::UHC_ENG_WAIT:
         begin
            if (x.done)
            begin
               d.st = uhc_pkg::UHC_ENG_IDLE;
               if (!x.ok)
               begin
                  d.launch_clr = 1'b1;
                  d.assist_clr = q.stage != uhc_pkg::STG_IDLE;
               end
               else if (q.stage != uhc_pkg::STG_IDLE)
               begin
                  if (q.stage == uhc_pkg::STG_STATUS)
                  begin
                     d.stage = uhc_pkg::STG_IDLE;
                     d.assist_clr = 1'b1;
                  end
                  else if (x.assist_go)
                  begin
                     d.st = uhc_pkg::UHC_ENG_WAIT;
                     d.tok_valid = 1'b1;
                     if (q.stage == uhc_pkg::STG_SETUP && x.plan_data)
                     begin
                        d.stage = uhc_pkg::STG_DATA; // RULE16
                        d.tok_kind = dkind;
                        d.tok_len = x.max_pkt;
                     end
                     else
                     begin
                        d.stage = uhc_pkg::STG_STATUS; // RULE16
                        d.tok_kind = skind;
                        d.tok_len = 7'h00;
                     end
                  end
               end
               else
               begin
                  d.dec = 1'b1; // RULE8
                  d.dec_bytes = x.bytes;
                  if (q.tok_kind == uhc_pkg::KIND_SETUP || x.remaining <= {9'h000, x.bytes}
                      || x.bytes < x.max_pkt)
                     d.launch_clr = 1'b1;
                  else if (x.launch)
                  begin
                     d.st = uhc_pkg::UHC_ENG_WAIT;
                     d.tok_valid = 1'b1;
                     d.tok_len = plain_len(q.tok_kind, x.max_pkt,
                                           x.remaining - {9'h000, x.bytes});
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q <= '{st: uhc_pkg::UHC_ENG_IDLE, stage: uhc_pkg::STG_IDLE, tok_kind: uhc_pkg::KIND_SETUP,
                default: '0};
      else
         q <= d;
   end

   assign x.tok_valid = q.tok_valid;
   assign x.tok_kind = q.tok_kind;
   assign x.tok_len = q.tok_len;
   assign x.stage = q.stage;
   assign x.launch_clr = q.launch_clr;
   assign x.assist_clr = q.assist_clr;
   assign x.dec = q.dec;
   assign x.dec_bytes = q.dec_bytes;

   // -------------------------------------------------------------
   // Checks.
   // -------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_plain_start;
      q.st == uhc_pkg::UHC_ENG_IDLE && x.launch && !x.assist_go && !q.launch_clr
      && !q.assist_clr;
   endsequence
   sequence s_setup_ok;
      q.st == uhc_pkg::UHC_ENG_WAIT && q.stage == uhc_pkg::STG_SETUP && x.done && x.ok
      && x.assist_go;
   endsequence

   a_launch_token_kind: // RULE1
      assert property (s_plain_start |=> q.tok_valid && q.tok_kind == $past(x.kind))
      else $error("Plain launch did not issue the programmed token kind.");
   a_assist_kind_ignored: // RULE3
      assert property (q.st == uhc_pkg::UHC_ENG_IDLE && x.assist_go && !q.assist_clr
                       |=> q.tok_valid && q.tok_kind == uhc_pkg::KIND_SETUP)
      else $error("Assist start did not issue a setup token.");
   a_zero_len_out: // RULE9
      assert property (s_plain_start ##0 (x.kind == uhc_pkg::KIND_OUT && x.remaining == 16'h0000)
                       |=> q.tok_len == 7'h00)
      else $error("Empty OUT transfer did not give a zero-length packet.");
   a_assist_stage_step: // RULE16
      assert property (s_setup_ok |=> q.tok_valid && q.stage != uhc_pkg::STG_SETUP)
      else $error("Assist did not leave the setup stage.");
endmodule // uhc_chan0_engine
`default_nettype wire

// ### hdl/uhc_chan0_regs.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// RULE1: Kind field 00 issues SETUP, 01 issues OUT, 10 issues IN.
// RULE2: Software never writes kind value 11.
// RULE3: With assist go set and running, the kind field is ignored.
// RULE4: Software may leave the kind field unset when assist is used.
// RULE5: Packet limit is seven bits 6..0; bit 7 reserved.
// RULE6: Software sets packet limit 8, 16, 32 or 64 per speed.
// RULE7: Byte budget is a sixteen-bit count, up to 65535 bytes.
// RULE8: After launch, the byte budget updates on each normal completion.
// RULE9: OUT launched with zero budget sends one zero-length packet.
// RULE10: Software may leave budget unset for SETUP or assisted transfers.
// RULE11: Hub route bits 7..4 hold the hub address 0 to 15.
// RULE12: Hub route bits 2..0 hold the hub port 0 to 7; bit 3 reserved.
// RULE13: Target route bits 7..4 hold the function address 0 to 15.
// RULE14: Target route bits 3..0 hold the endpoint index 0 to 15.
// RULE15: Writing launch one starts, zero stops; it reads back running.
// RULE16: Assist go steps setup, optional data and status stages itself.
// RULE17: Each normal completion subtracts the bytes moved, stopping at zero.
module uhc_chan0_regs
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             tok_valid,
   output logic      [1:0]  tok_kind,
   output logic      [6:0]  tok_len,
   output logic      [3:0]  tok_hub_addr,
   output logic      [2:0]  tok_hub_port,
   output logic      [3:0]  tok_func_addr,
   output logic      [3:0]  tok_endpoint,
   input  wire logic        xact_done,
   input  wire logic        xact_ok,
   input  wire logic [6:0]  xact_bytes
);
   // -------------------------------------------------------------
   // State.
   // -------------------------------------------------------------
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        launch;
      logic        assist_go;
      logic [1:0]  kind;
      logic [6:0]  max_pkt;
      logic [15:0] budget;
      logic [3:0]  hub_addr;
      logic [2:0]  hub_port;
      logic [3:0]  func_addr;
      logic [3:0]  endpoint;
      logic        plan_data;
      logic        plan_in;
   } uhc_regs_state_t;

   uhc_regs_state_t q;
   uhc_regs_state_t d;
   uhc_xact_if      x ();

   logic [9:0]  idx;
   logic        hit;
   logic [31:0] rd;
   logic        wr;

   assign idx = paddr[11:2];

   // -------------------------------------------------------------
   // Read decode.
   // -------------------------------------------------------------
   always_comb
   begin
      hit = 1'b1;
      rd = 32'h0000_0000;
      unique case (idx)
         uhc_pkg::IDX_CTRL:
            rd[0] = q.launch; // RULE15
         uhc_pkg::IDX_TOKEN:
            rd[uhc_pkg::KIND_LSB +: 2] = q.kind;
         uhc_pkg::IDX_PKT:
            rd[6:0] = q.max_pkt; // RULE5
         uhc_pkg::IDX_BUDGET:
            rd[15:0] = q.budget; // RULE7
         uhc_pkg::IDX_HUB:
         begin
            rd[uhc_pkg::HUB_LSB +: 4] = q.hub_addr; // RULE11
            rd[2:0] = q.hub_port; // RULE12
         end
         uhc_pkg::IDX_TARGET:
         begin
            rd[uhc_pkg::FUNC_LSB +: 4] = q.func_addr; // RULE13
            rd[3:0] = q.endpoint; // RULE14
         end
         uhc_pkg::IDX_ASSIST:
         begin
            rd[0] = q.assist_go;
            rd[uhc_pkg::STAGE_LSB +: 2] = x.stage;
         end
         uhc_pkg::IDX_PLAN:
         begin
            rd[0] = q.plan_data;
            rd[uhc_pkg::PLAN_IN] = q.plan_in;
         end
         default:
            hit = 1'b0;
      endcase
   end

   // -------------------------------------------------------------
   // Next state.
   // -------------------------------------------------------------
   always_comb
   begin
      d = q;
      wr = psel && penable && q.pready && pwrite && !q.pslverr;
      d.pready = psel && !penable;
      d.pslverr = psel && !penable && (!hit || paddr[1:0] != 2'h0);
      d.prdata = (psel && !penable && !pwrite && hit) ? rd : 32'h0000_0000;
      if (x.launch_clr)
         d.launch = 1'b0;
      if (x.assist_clr)
         d.assist_go = 1'b0;
      if (x.dec)
         d.budget = (q.budget > {9'h000, x.dec_bytes})
                    ? q.budget - {9'h000, x.dec_bytes} : 16'h0000; // RULE17
      if (wr)
      begin
         unique case (idx)
            uhc_pkg::IDX_CTRL:
               d.launch = pwdata[0]; // RULE15
            uhc_pkg::IDX_TOKEN:
               d.kind = pwdata[uhc_pkg::KIND_LSB +: 2];
            uhc_pkg::IDX_PKT:
               d.max_pkt = pwdata[6:0]; // RULE5
            uhc_pkg::IDX_BUDGET:
               d.budget = pwdata[15:0]; // RULE7
            uhc_pkg::IDX_HUB:
            begin
               d.hub_addr = pwdata[uhc_pkg::HUB_LSB +: 4]; // RULE11
               d.hub_port = pwdata[2:0]; // RULE12
            end
            uhc_pkg::IDX_TARGET:
            begin
               d.func_addr = pwdata[uhc_pkg::FUNC_LSB +: 4]; // RULE13
               d.endpoint = pwdata[3:0]; // RULE14
            end
            uhc_pkg::IDX_ASSIST:
               d.assist_go = pwdata[0]; // RULE16
            uhc_pkg::IDX_PLAN:
            begin
               d.plan_data = pwdata[0];
               d.plan_in = pwdata[uhc_pkg::PLAN_IN];
            end
            default:
               d.launch = d.launch;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q <= '{kind: uhc_pkg::KIND_SETUP, max_pkt: uhc_pkg::RST_PKT,
                budget: uhc_pkg::RST_BUDGET, hub_addr: uhc_pkg::RST_NIBBLE,
                hub_port: uhc_pkg::RST_PORT, func_addr: uhc_pkg::RST_NIBBLE,
                endpoint: uhc_pkg::RST_NIBBLE, default: '0};
      else
         q <= d;
   end

   // -------------------------------------------------------------
   // Transaction engine.
   // -------------------------------------------------------------
   assign x.launch = q.launch;
   assign x.assist_go = q.assist_go;
   assign x.kind = q.kind;
   assign x.max_pkt = q.max_pkt;
   assign x.remaining = q.budget;
   assign x.plan_data = q.plan_data;
   assign x.plan_in = q.plan_in;
   assign x.done = xact_done;
   assign x.ok = xact_ok;
   assign x.bytes = xact_bytes;

   uhc_chan0_engine u_engine
   (
      .pclk    (pclk),
      .presetn (presetn),
      .x       (x.eng)
   );

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign tok_valid = x.tok_valid;
   assign tok_kind = x.tok_kind;
   assign tok_len = x.tok_len;
   assign tok_hub_addr = q.hub_addr;
   assign tok_hub_port = q.hub_port;
   assign tok_func_addr = q.func_addr;
   assign tok_endpoint = q.endpoint;

   // -------------------------------------------------------------
   // Checks.
   // -------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_read(logic [9:0] r);
      psel && !penable && !pwrite && idx == r && paddr[1:0] == 2'h0;
   endsequence

   a_pkt_reserved_zero: // RULE5
      assert property (s_read(uhc_pkg::IDX_PKT) |=> pready && prdata[31:7] == 25'h0
                       && prdata[6:0] == q.max_pkt)
      else $error("Packet limit read shows reserved bits or wrong value.");
   a_budget_readback: // RULE7
      assert property (s_read(uhc_pkg::IDX_BUDGET) |=> prdata == {16'h0000, $past(q.budget)})
      else $error("Byte budget read does not match the count.");
   a_hub_route_read: // RULE12
      assert property (s_read(uhc_pkg::IDX_HUB) |=> prdata[7:0] == {q.hub_addr, 1'b0, q.hub_port})
      else $error("Hub route read has wrong layout.");
   a_target_route_read: // RULE14
      assert property (s_read(uhc_pkg::IDX_TARGET) |=> prdata[7:0] == {q.func_addr, q.endpoint})
      else $error("Target route read has wrong layout.");
   a_budget_saturates: // RULE17
      assert property (x.dec && !wr |=> q.budget == (($past(q.budget) > {9'h000, $past(x.dec_bytes)})
                       ? $past(q.budget) - {9'h000, $past(x.dec_bytes)} : 16'h0000))
      else $error("Byte budget did not drop by the bytes moved.");
   a_launch_issues: // RULE15
      assert property ($rose(q.launch) && !q.assist_go && !x.tok_valid && x.stage == uhc_pkg::STG_IDLE
                       && !x.launch_clr && !x.assist_clr
                       && u_engine.q.st == uhc_pkg::UHC_ENG_IDLE
                       |-> ##[0:1] tok_valid)
      else $error("Launch did not issue a token.");
endmodule // uhc_chan0_regs
`default_nettype wire

// ### inc/uhc_pkg.sv
package uhc_pkg;
   // -------------------------------------------------------------
   // Bus geometry and register indices (byte address is index * 4).
   // -------------------------------------------------------------
   localparam int unsigned ADDR_W     = 12;
   localparam int unsigned DATA_W     = 32;
   localparam logic [9:0]  IDX_CTRL   = 10'h180;
   localparam logic [9:0]  IDX_TOKEN  = 10'h181;
   localparam logic [9:0]  IDX_PKT    = 10'h183;
   localparam logic [9:0]  IDX_BUDGET = 10'h186;
   localparam logic [9:0]  IDX_HUB    = 10'h188;
   localparam logic [9:0]  IDX_TARGET = 10'h189;
   localparam logic [9:0]  IDX_ASSIST = 10'h18b;
   localparam logic [9:0]  IDX_PLAN   = 10'h18c;
   // -------------------------------------------------------------
   // Field positions.
   // -------------------------------------------------------------
   localparam int unsigned KIND_LSB  = 6;
   localparam int unsigned HUB_LSB   = 4;
   localparam int unsigned FUNC_LSB  = 4;
   localparam int unsigned STAGE_LSB = 4;
   localparam int unsigned PLAN_IN   = 1;
   // -------------------------------------------------------------
   // Encodings, reset values and sizes.
   // -------------------------------------------------------------
   localparam logic [1:0]  KIND_SETUP  = 2'h0;
   localparam logic [1:0]  KIND_OUT    = 2'h1;
   localparam logic [1:0]  KIND_IN     = 2'h2;
   localparam logic [1:0]  STG_IDLE    = 2'h0;
   localparam logic [1:0]  STG_SETUP   = 2'h1;
   localparam logic [1:0]  STG_DATA    = 2'h2;
   localparam logic [1:0]  STG_STATUS  = 2'h3;
   localparam logic [6:0]  SETUP_LEN   = 7'h08;
   localparam logic [6:0]  RST_PKT     = 7'h00;
   localparam logic [15:0] RST_BUDGET  = 16'h0000;
   localparam logic [3:0]  RST_NIBBLE  = 4'h0;
   localparam logic [2:0]  RST_PORT    = 3'h0;

   typedef enum logic [1:0] {
      UHC_ENG_IDLE = 2'b01,
      UHC_ENG_WAIT = 2'b10
   } uhc_eng_t;
endpackage

// ### inc/uhc_xact_if.sv
`timescale 1ns/10ps
`default_nettype none
interface uhc_xact_if;
   logic        launch;
   logic        assist_go;
   logic [1:0]  kind;
   logic [6:0]  max_pkt;
   logic [15:0] remaining;
   logic        plan_data;
   logic        plan_in;
   logic        done;
   logic        ok;
   logic [6:0]  bytes;
   logic        tok_valid;
   logic [1:0]  tok_kind;
   logic [6:0]  tok_len;
   logic [1:0]  stage;
   logic        launch_clr;
   logic        assist_clr;
   logic        dec;
   logic [6:0]  dec_bytes;

   modport regs (output launch, assist_go, kind, max_pkt, remaining, plan_data, plan_in,
                 done, ok, bytes,
                 input tok_valid, tok_kind, tok_len, stage, launch_clr, assist_clr, dec,
                 dec_bytes);
   modport eng (input launch, assist_go, kind, max_pkt, remaining, plan_data, plan_in,
                done, ok, bytes,
                output tok_valid, tok_kind, tok_len, stage, launch_clr, assist_clr, dec,
                dec_bytes);
endinterface
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) \
   begin \
      check_count++; \
      if ((g) !== (e)) \
      begin \
         err_count++; \
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (g), (e)); \
      end \
   end
// ---------------------------------------------------------------
// Register bank bench: APB accesses, token watch, verdict.
// ---------------------------------------------------------------
module tb;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        tok_valid;
   logic [1:0]  tok_kind;
   logic [6:0]  tok_len;
   logic [3:0]  tok_hub_addr;
   logic [2:0]  tok_hub_port;
   logic [3:0]  tok_func_addr;
   logic [3:0]  tok_endpoint;
   logic        xact_done;
   logic        xact_ok;
   logic [6:0]  xact_bytes;
   logic [3:0]  ans_delay;
   logic        ans_fail;
   logic [6:0]  ans_short;
   logic [31:0] rd_d;
   logic        rd_e;
   logic [8:0]  tq [$];
   logic [1:0]  plans [3] = '{2'h1, 2'h0, 2'h3};
   int          err_count;
   int          check_count;
   int          cycles;

   uhc_chan0_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tok_valid(tok_valid), .tok_kind(tok_kind), .tok_len(tok_len),
      .tok_hub_addr(tok_hub_addr), .tok_hub_port(tok_hub_port),
      .tok_func_addr(tok_func_addr), .tok_endpoint(tok_endpoint), .xact_done(xact_done),
      .xact_ok(xact_ok), .xact_bytes(xact_bytes));

   uhc_func_model func (.pclk(pclk), .presetn(presetn), .tok_valid(tok_valid),
      .tok_len(tok_len), .ans_delay(ans_delay), .ans_fail(ans_fail), .ans_short(ans_short),
      .xact_done(xact_done), .xact_ok(xact_ok), .xact_bytes(xact_bytes));

   always #25 pclk = ~pclk;

   always @(posedge pclk)
   begin
      if (tok_valid === 1'b1)
         tq.push_back({tok_kind, tok_len});
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: run did not finish", $time);
         report_and_stop;
      end
   end

   task automatic apb(input logic [9:0] idx, input logic wr, input logic [31:0] wd);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd_d = prdata;
      rd_e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
      apb(idx, 1'b0, 32'h0);
      `CHK(rd_d, exp)
      `CHK(rd_e, 1'b0)
   endtask

   task automatic chk_tok(input logic [1:0] kind, input logic [6:0] len);
      logic [8:0] t;
      t = (tq.size() > 0) ? tq.pop_front() : 9'h1ff;
      `CHK(t, {kind, len})
   endtask

   task automatic wait_clear(input logic [9:0] idx);
      do
      begin
         apb(idx, 1'b0, 32'h0);
      end
      while (rd_d[0] !== 1'b0);
   endtask

   task automatic xfer(input logic [1:0] kind, input logic [15:0] budget);
      apb(uhc_pkg::IDX_TOKEN, 1'b1, {24'h0, kind, 6'h00});
      apb(uhc_pkg::IDX_BUDGET, 1'b1, {16'h0, budget});
      apb(uhc_pkg::IDX_CTRL, 1'b1, 32'h1);
      wait_clear(uhc_pkg::IDX_CTRL);
   endtask

   task report_and_stop;
      $display("Checks: %0d, mismatches: %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      ans_delay = 4'h0;
      ans_fail = 1'b0;
      ans_short = 7'h00;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK(tok_valid, 1'b0)
      rd_chk(uhc_pkg::IDX_PKT, 32'h0);
      rd_chk(uhc_pkg::IDX_BUDGET, 32'h0);
      rd_chk(uhc_pkg::IDX_TARGET, 32'h0);
      apb(uhc_pkg::IDX_PKT, 1'b1, 32'hffffffff);
      rd_chk(uhc_pkg::IDX_PKT, 32'h7f);
      apb(uhc_pkg::IDX_BUDGET, 1'b1, 32'hffffffff);
      rd_chk(uhc_pkg::IDX_BUDGET, 32'hffff);
      apb(uhc_pkg::IDX_HUB, 1'b1, 32'had);
      rd_chk(uhc_pkg::IDX_HUB, 32'ha5);
      `CHK(tok_hub_addr, 4'ha)
      `CHK(tok_hub_port, 3'h5)
      apb(uhc_pkg::IDX_TARGET, 1'b1, 32'h3c);
      rd_chk(uhc_pkg::IDX_TARGET, 32'h3c);
      `CHK(tok_func_addr, 4'h3)
      `CHK(tok_endpoint, 4'hc)
      apb(uhc_pkg::IDX_TOKEN, 1'b1, 32'hbf);
      rd_chk(uhc_pkg::IDX_TOKEN, 32'h80);
      apb(10'h182, 1'b1, 32'hffffffff);
      `CHK(rd_e, 1'b1)
      apb(10'h182, 1'b0, 32'h0);
      `CHK(rd_e, 1'b1)
      `CHK(rd_d, 32'h0)
      apb(uhc_pkg::IDX_PKT, 1'b1, 32'h8);
      xfer(uhc_pkg::KIND_SETUP, 16'h0);
      chk_tok(uhc_pkg::KIND_SETUP, 7'h08);
      xfer(uhc_pkg::KIND_OUT, 16'h14);
      chk_tok(uhc_pkg::KIND_OUT, 7'h08);
      chk_tok(uhc_pkg::KIND_OUT, 7'h08);
      chk_tok(uhc_pkg::KIND_OUT, 7'h04);
      rd_chk(uhc_pkg::IDX_BUDGET, 32'h0);
      xfer(uhc_pkg::KIND_OUT, 16'h0);
      chk_tok(uhc_pkg::KIND_OUT, 7'h00);
      ans_short <= 7'h03;
      xfer(uhc_pkg::KIND_IN, 16'h14);
      chk_tok(uhc_pkg::KIND_IN, 7'h08);
      rd_chk(uhc_pkg::IDX_BUDGET, 32'h11);
      ans_short <= 7'h00;
      ans_fail <= 1'b1;
      xfer(uhc_pkg::KIND_OUT, 16'h10);
      chk_tok(uhc_pkg::KIND_OUT, 7'h08);
      rd_chk(uhc_pkg::IDX_BUDGET, 32'h10);
      ans_fail <= 1'b0;
      ans_delay <= 4'hc;
      apb(uhc_pkg::IDX_TOKEN, 1'b1, 32'h80);
      apb(uhc_pkg::IDX_BUDGET, 1'b1, 32'h28);
      apb(uhc_pkg::IDX_CTRL, 1'b1, 32'h1);
      rd_chk(uhc_pkg::IDX_CTRL, 32'h1);
      apb(uhc_pkg::IDX_CTRL, 1'b1, 32'h0);
      repeat (30) @(posedge pclk);
      chk_tok(uhc_pkg::KIND_IN, 7'h08);
      rd_chk(uhc_pkg::IDX_CTRL, 32'h0);
      rd_chk(uhc_pkg::IDX_BUDGET, 32'h20);
      ans_delay <= 4'h0;
      for (int i = 0; i < 3; i++)
      begin
         apb(uhc_pkg::IDX_TOKEN, 1'b1, 32'h40);
         apb(uhc_pkg::IDX_PLAN, 1'b1, {30'h0, plans[i]});
         apb(uhc_pkg::IDX_ASSIST, 1'b1, 32'h1);
         wait_clear(uhc_pkg::IDX_ASSIST);
         `CHK(rd_d, 32'h0)
         chk_tok(uhc_pkg::KIND_SETUP, uhc_pkg::SETUP_LEN);
         if (plans[i][0])
            chk_tok(plans[i][1] ? uhc_pkg::KIND_IN : uhc_pkg::KIND_OUT, 7'h08);
         chk_tok(plans[i] == 2'h3 ? uhc_pkg::KIND_OUT : uhc_pkg::KIND_IN, 7'h00);
      end
      `CHK(tq.size(), 0)
      report_and_stop;
   end
endmodule // tb
`default_nettype wire

// ### verification/uhc_func_model.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// Attached function: answers each token once after a set delay.
// ---------------------------------------------------------------
module uhc_func_model
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       tok_valid,
   input  wire logic [6:0] tok_len,
   input  wire logic [3:0] ans_delay,
   input  wire logic       ans_fail,
   input  wire logic [6:0] ans_short,
   output logic            xact_done,
   output logic            xact_ok,
   output logic      [6:0] xact_bytes
);
   logic       busy_q;
   logic [3:0] cnt_q;
   logic [6:0] len_q;
   logic [6:0] bytes_q;
   logic       ok_q;

   // Outside an answer the result lines show the inverse of the last answer.
   assign xact_ok    = xact_done ? ok_q : !ok_q;
   assign xact_bytes = xact_done ? bytes_q : ~bytes_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         busy_q    <= 1'b0;
         cnt_q     <= 4'h0;
         len_q     <= 7'h00;
         bytes_q   <= 7'h00;
         ok_q      <= 1'b0;
         xact_done <= 1'b0;
      end
      else
      begin
         xact_done <= 1'b0;
         if (tok_valid)
         begin
            busy_q <= 1'b1;
            cnt_q  <= ans_delay;
            len_q  <= tok_len;
         end
         else if (busy_q && cnt_q == 4'h0)
         begin
            busy_q    <= 1'b0;
            xact_done <= 1'b1;
            ok_q      <= !ans_fail;
            bytes_q   <= (ans_short != 7'h00 && ans_short < len_q) ? ans_short : len_q;
         end
         else if (busy_q)
         begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
endmodule // uhc_func_model
`default_nettype wire
